/* File: src/outstage_map.svh */
// register offsets, field positions, reset values and timing intervals in ns for the output-stage block
`ifndef OUTSTAGE_MAP_SVH
`define OUTSTAGE_MAP_SVH
// byte addresses: page * 0x100 + register * 4
`define A_SOFTSTEP     12'h0FC
`define A_HP_FLAGS     12'h0B0
`define A_SPK_FLAGS    12'h0B4
`define A_POR_CTRL     12'h104
`define A_REG_VSEL     12'h108
`define A_HP_ENABLE    12'h124
`define A_HP_DRIVE     12'h128
`define A_HP_SHORT     12'h12C
`define A_ROUTE        12'h130
`define A_HP_GAIN      12'h140
`define A_SPK_ENABLE   12'h1B4
`define A_SPK_VOL      12'h1B8
`define A_SPK_GAIN     12'h1C0
`define A_SW_RESET     12'h004
// field positions
`define B_STEP_LO      0
`define B_STEP_HI      1
`define B_HP_SHORT_FL  7
`define B_OTP_FL       7
`define B_POR_DIS      3
`define B_VSEL_LO      4
`define B_VSEL_HI      5
`define B_HP_EN        5
`define B_HALF_DRIVE   2
`define B_SHUTDOWN_MODE 1
`define B_SPK_ROUTE    3
`define B_HP_GAIN_LO   0
`define B_HP_GAIN_HI   5
`define B_HP_MUTE      6
`define B_SPK_EN       1
`define B_VOL_LO       0
`define B_VOL_HI       6
`define B_SPK_GAIN_LO  4
`define B_SPK_GAIN_HI  6
`define B_SW_RESET     0
// reset values and encodings
`define R_HP_MUTE      1'b1
`define R_HP_GAIN      6'h00
`define R_SPK_GAIN     3'h1
`define R_VOL          7'h7F
`define R_STEP         2'h0
`define R_VSEL         2'h0
`define V_SPK_MUTE     3'h0
`define V_VOL_MAX      7'h75
// soft-step intervals in ns per setting
`define T_STEP0_NS     62500
`define T_STEP1_NS     125000
`define T_STEP2_NS     250000
`endif

/* File: src/outstage_pkg.sv */
// types shared by the output-stage control block
package outstage_pkg;
  typedef enum logic [1:0] {
    STEP_IDLE = 2'h0,
    STEP_WAIT = 2'h1,
    STEP_MOVE = 2'h3
  } step_state_t;

  typedef struct packed {
    logic [6:0] target;
    logic [6:0] current;
    logic [15:0] count;
    step_state_t state;
  } step_regs_t;

  typedef struct packed {
    logic half_drive;
    logic shutdown_mode;
    logic spk_route;
    logic hp_en;
    logic hp_mute;
    logic [5:0] hp_gain;
    logic spk_en;
    logic [2:0] spk_gain;
    logic [6:0] spk_vol;
    logic [1:0] step_sel;
    logic [1:0] vsel;
    logic por_dis;
    logic [31:0] prdata;
    logic sw_reset;
  } ctrl_regs_t;

  typedef struct packed {
    logic hp_on;
    logic hp_limit;
    logic hp_half;
    logic hp_mute;
    logic [5:0] hp_gain;
    logic spk_on;
    logic spk_switch;
    logic [2:0] spk_gain;
    logic [6:0] spk_atten;
    logic spk_route;
  } drive_t;
endpackage : outstage_pkg

/* File: src/outstage_softstep.sv */
// soft-step engine: walks the applied attenuation code one step per interval
`timescale 1ns/1ns
`default_nettype none
`include "outstage_map.svh"
module outstage_softstep import outstage_pkg::*; #(
  parameter int CLK_HZ = 10000000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [6:0] target_in,
  input wire logic [1:0] step_sel_in,
  output logic [6:0] code_out
);
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam logic [15:0] N0 = 16'((`T_STEP0_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] N1 = 16'((`T_STEP1_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] N2 = 16'((`T_STEP2_NS * CLK_MHZ) / 1000);

  step_regs_t r;
  step_regs_t next_r;

  // codes above the max-attenuation point all mean the same level
  function automatic logic [6:0] clamp(input logic [6:0] c);
    clamp = (c > `V_VOL_MAX) ? `V_VOL_MAX : c;
  endfunction : clamp

  function automatic logic [15:0] interval(input logic [1:0] s);
    unique case (s)
      2'h0: interval = N0;
      2'h1: interval = N1;
      2'h2: interval = N2;
      2'h3: interval = 16'h0001;
    endcase
  endfunction : interval

  always_comb begin
    next_r = r;
    next_r.target = clamp(target_in);
    unique case (r.state)
      STEP_IDLE: begin
        if (r.current != next_r.target) begin
          next_r.count = interval(step_sel_in);
          next_r.state = STEP_WAIT;
        end
      end
      STEP_WAIT: begin
        if (r.count <= 16'h0001) begin
          next_r.state = STEP_MOVE;
        end else begin
          next_r.count = r.count - 16'h0001;
        end
      end
      STEP_MOVE: begin
        // one code per interval avoids audible zipper jumps
        if (r.current < r.target) begin
          next_r.current = r.current + 7'h01;
        end else if (r.current > r.target) begin
          next_r.current = r.current - 7'h01;
        end
        next_r.state = STEP_IDLE;
      end
      default: next_r.state = STEP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{target: `V_VOL_MAX, current: `V_VOL_MAX, count: 16'h0000, state: STEP_IDLE};
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign code_out = r.current;
endmodule : outstage_softstep
`default_nettype wire

/* File: src/outstage_ctrl.sv */
// output-stage control: registers, fault shutdown, re-arm, thermal and regulator control
// Function
// - speaker attenuation 0 to about -78 dB, half-dB steps, mute, soft-stepped
// - page 1 reg 12 bit 3 routes converter through mixers to speaker volume
// - speaker volume is seven bits 6..0 of page 1 reg 46
// - page 0 reg 63 bits 1..0 choose the soft-step interval
// - page 1 reg 10 bit 2 selects headphone half-drive line-capable mode
// - page 1 reg 9 bit 5 powers headphone driver up or down
// - headphone gain bits 5..0 and mute bit 6 of page 1 reg 16
// - page 1 reg 11 bit 1: zero limits current, one shuts down
// - headphone short flag readable at page 0 reg 44 bit 7
// - in shutdown mode a short clears the headphone enable bit
// - setting headphone enable again re-arms only that stage
// - pin or software reset restores all register defaults
// - page 1 reg 45 bit 1 powers the class-D speaker driver
// - speaker gain bits 6..4 of page 1 reg 48, zero mutes
// - speaker overcurrent always shuts down and clears the speaker enable
// - setting speaker enable again re-arms only the speaker stage
// - over-temperature stops speaker switching, flag at page 0 reg 45 bit 7
// - page 1 reg 2 bits 5..4 select regulator output voltage
// - regulator off unless select pin tied to speaker supply; off means tri-state
// - power-on reset loads defaults; page 1 reg 1 bit 3 disables it
// - volume codes 117 to 127 all give maximum attenuation
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "outstage_map.svh"
module outstage_ctrl import outstage_pkg::*; #(
  parameter int CLK_HZ = 10000000
) (
  // clock, reset, enable
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic POR_B_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // analog fault sense and regulator select pin (asynchronous)
  input wire logic HP_SHORT_IN,
  input wire logic SPK_OVERCURRENT_IN,
  input wire logic OVER_TEMP_IN,
  input wire logic REGULATOR_SELECT_PIN_IN,
  // driver controls
  output drive_t DRIVE_OUT,
  // regulator controls
  output logic REG_ENABLE_OUT,
  output logic [1:0] REG_VSEL_OUT,
  output logic ANALOG_SUPPLY_OE_OUT,
  output logic CORE_SUPPLY_OE_OUT,
  output logic POR_ENABLE_OUT
);
  // ----------------------------------------------------------------
  // reset and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;
  logic [1:0] por_sync;
  logic por_ok;
  logic [1:0] hp_s;
  logic [1:0] spk_s;
  logic [1:0] otp_s;
  logic [1:0] sel_s;
  logic soft_rst_n;
  ctrl_regs_t r;
  ctrl_regs_t next_r;
  logic [6:0] vol_code;

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // power-on reset input counts only while not disabled
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      por_sync <= 2'h3;
      hp_s <= 2'h0;
      spk_s <= 2'h0;
      otp_s <= 2'h0;
      sel_s <= 2'h0;
    end else if (CE_IN) begin
      por_sync <= {por_sync[0], POR_B_IN};
      hp_s <= {hp_s[0], HP_SHORT_IN};
      spk_s <= {spk_s[0], SPK_OVERCURRENT_IN};
      otp_s <= {otp_s[0], OVER_TEMP_IN};
      sel_s <= {sel_s[0], REGULATOR_SELECT_PIN_IN};
    end
  end
  assign por_ok = por_sync[1] | r.por_dis;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic wr;
  logic rd_setup;
  logic mapped;
  logic hp_fault;
  logic spk_fault;

  function automatic logic is_mapped(input logic [11:0] a);
    unique case (a)
      `A_SOFTSTEP, `A_HP_FLAGS, `A_SPK_FLAGS, `A_POR_CTRL, `A_REG_VSEL,
      `A_HP_ENABLE, `A_HP_DRIVE, `A_HP_SHORT, `A_ROUTE, `A_HP_GAIN,
      `A_SPK_ENABLE, `A_SPK_VOL, `A_SPK_GAIN, `A_SW_RESET: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign mapped = is_mapped(PADDR_IN);
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN & mapped;
  assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  // zero-wait slave: read data registered in setup, valid in access
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
  assign PRDATA_OUT = r.prdata;

  assign hp_fault = hp_s[1] & r.hp_en & r.shutdown_mode;
  assign spk_fault = spk_s[1] & r.spk_en;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.sw_reset = 1'b0;
    if (wr) begin
      unique case (PADDR_IN)
        `A_SOFTSTEP: next_r.step_sel = PWDATA_IN[`B_STEP_HI:`B_STEP_LO];
        `A_POR_CTRL: next_r.por_dis = PWDATA_IN[`B_POR_DIS];
        `A_REG_VSEL: next_r.vsel = PWDATA_IN[`B_VSEL_HI:`B_VSEL_LO];
        `A_HP_ENABLE: next_r.hp_en = PWDATA_IN[`B_HP_EN];
        `A_HP_DRIVE: next_r.half_drive = PWDATA_IN[`B_HALF_DRIVE];
        `A_HP_SHORT: next_r.shutdown_mode = PWDATA_IN[`B_SHUTDOWN_MODE];
        `A_ROUTE: next_r.spk_route = PWDATA_IN[`B_SPK_ROUTE];
        `A_HP_GAIN: begin
          next_r.hp_gain = PWDATA_IN[`B_HP_GAIN_HI:`B_HP_GAIN_LO];
          next_r.hp_mute = PWDATA_IN[`B_HP_MUTE];
        end
        `A_SPK_ENABLE: next_r.spk_en = PWDATA_IN[`B_SPK_EN];
        `A_SPK_VOL: next_r.spk_vol = PWDATA_IN[`B_VOL_HI:`B_VOL_LO];
        `A_SPK_GAIN: next_r.spk_gain = PWDATA_IN[`B_SPK_GAIN_HI:`B_SPK_GAIN_LO];
        `A_SW_RESET: next_r.sw_reset = PWDATA_IN[`B_SW_RESET];
        default: next_r.sw_reset = 1'b0;
      endcase
    end
    // a speaker overcurrent, or a headphone short in shutdown mode, clears a running stage's enable even against a write; a re-arm write turns it on for one cycle
    if (hp_fault) begin
      next_r.hp_en = 1'b0;
    end
    if (spk_fault) begin
      next_r.spk_en = 1'b0;
    end
    next_r.prdata = 32'h0000_0000;
    if (rd_setup) begin
      unique case (PADDR_IN)
        `A_SOFTSTEP: next_r.prdata[`B_STEP_HI:`B_STEP_LO] = r.step_sel;
        `A_HP_FLAGS: next_r.prdata[`B_HP_SHORT_FL] = hp_s[1];
        `A_SPK_FLAGS: next_r.prdata[`B_OTP_FL] = otp_s[1];
        `A_POR_CTRL: next_r.prdata[`B_POR_DIS] = r.por_dis;
        `A_REG_VSEL: next_r.prdata[`B_VSEL_HI:`B_VSEL_LO] = r.vsel;
        `A_HP_ENABLE: next_r.prdata[`B_HP_EN] = r.hp_en;
        `A_HP_DRIVE: next_r.prdata[`B_HALF_DRIVE] = r.half_drive;
        `A_HP_SHORT: next_r.prdata[`B_SHUTDOWN_MODE] = r.shutdown_mode;
        `A_ROUTE: next_r.prdata[`B_SPK_ROUTE] = r.spk_route;
        `A_HP_GAIN: begin
          next_r.prdata[`B_HP_GAIN_HI:`B_HP_GAIN_LO] = r.hp_gain;
          next_r.prdata[`B_HP_MUTE] = r.hp_mute;
        end
        `A_SPK_ENABLE: next_r.prdata[`B_SPK_EN] = r.spk_en;
        `A_SPK_VOL: next_r.prdata[`B_VOL_HI:`B_VOL_LO] = r.spk_vol;
        `A_SPK_GAIN: next_r.prdata[`B_SPK_GAIN_HI:`B_SPK_GAIN_LO] = r.spk_gain;
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end
  end

  // soft reset: software reset pulse, or power-on reset unless disabled; the pin reset acts through rst_n
  assign soft_rst_n = ~r.sw_reset & por_ok;

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.hp_mute <= `R_HP_MUTE;
      r.hp_gain <= `R_HP_GAIN;
      r.spk_gain <= `R_SPK_GAIN;
      r.spk_vol <= `R_VOL;
      r.step_sel <= `R_STEP;
      r.vsel <= `R_VSEL;
    end else if (CE_IN) begin
      if (!soft_rst_n) begin
        // defaults again; stages that were fault-shut are re-enabled by software later
        r <= '0;
        r.hp_mute <= `R_HP_MUTE;
        r.hp_gain <= `R_HP_GAIN;
        r.spk_gain <= `R_SPK_GAIN;
        r.spk_vol <= `R_VOL;
        r.step_sel <= `R_STEP;
        r.vsel <= `R_VSEL;
      end else begin
        r <= next_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // soft-stepped speaker volume
  // ----------------------------------------------------------------
  outstage_softstep #(
    .CLK_HZ(CLK_HZ)
  ) outstage_softstep_inst (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    .ce_in(CE_IN),
    .target_in(r.spk_vol),
    .step_sel_in(r.step_sel),
    .code_out(vol_code)
  );

  // ----------------------------------------------------------------
  // driver and regulator outputs
  // ----------------------------------------------------------------
  drive_t drv;
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      drv <= '0;
      REG_ENABLE_OUT <= 1'b0;
      REG_VSEL_OUT <= `R_VSEL;
      POR_ENABLE_OUT <= 1'b1;
    end else if (CE_IN) begin
      drv.hp_on <= r.hp_en;
      // current limit on any short while shutdown mode is off, whether or not the stage is enabled
      drv.hp_limit <= hp_s[1] & ~r.shutdown_mode;
      drv.hp_half <= r.half_drive;
      drv.hp_mute <= r.hp_mute;
      drv.hp_gain <= r.hp_gain;
      drv.spk_on <= r.spk_en;
      drv.spk_switch <= r.spk_en & ~otp_s[1];
      drv.spk_gain <= r.spk_gain;
      drv.spk_atten <= vol_code;
      drv.spk_route <= r.spk_route;
      REG_ENABLE_OUT <= sel_s[1];
      REG_VSEL_OUT <= r.vsel;
      POR_ENABLE_OUT <= ~r.por_dis;
    end
  end
  assign DRIVE_OUT = drv;
  // a disabled regulator leaves its supply pins undriven
  assign ANALOG_SUPPLY_OE_OUT = REG_ENABLE_OUT;
  assign CORE_SUPPLY_OE_OUT = REG_ENABLE_OUT;
endmodule : outstage_ctrl
`default_nettype wire

/* File: testbench/outstage_ctrl_asserts.sv */
// concurrent checks on the ports of the output-stage control block
`timescale 1ns/1ns
`default_nettype none
`include "outstage_map.svh"
module outstage_ctrl_asserts import outstage_pkg::*; (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  input wire logic POR_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  input wire logic SPK_OVERCURRENT_IN,
  input wire logic OVER_TEMP_IN,
  input wire logic REGULATOR_SELECT_PIN_IN,
  input wire drive_t DRIVE_OUT,
  input wire logic REG_ENABLE_OUT,
  input wire logic [1:0] REG_VSEL_OUT,
  input wire logic ANALOG_SUPPLY_OE_OUT,
  input wire logic CORE_SUPPLY_OE_OUT,
  input wire logic POR_ENABLE_OUT
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // frozen or power-on-held cycles lose writes, so they are not judged
  wire logic wr_ok = PSEL_IN && PENABLE_IN && PWRITE_IN && CE_IN && POR_B_IN;

  chk_atten_clamp: assert property (DRIVE_OUT.spk_atten <= `V_VOL_MAX)
    else $error("speaker attenuation above its floor code");
  chk_otp_quiet: assert property (OVER_TEMP_IN [*8] |-> !DRIVE_OUT.spk_switch)
    else $error("speaker switching while overheated");
  chk_oc_shutdown: assert property (SPK_OVERCURRENT_IN [*8] |-> !DRIVE_OUT.spk_on)
    else $error("speaker stage on during overcurrent");
  chk_supply_tristate: assert property (ANALOG_SUPPLY_OE_OUT == REG_ENABLE_OUT
    && CORE_SUPPLY_OE_OUT == REG_ENABLE_OUT) else $error("supply enables disagree");
  chk_regulator_pin: assert property ((REGULATOR_SELECT_PIN_IN && CE_IN) [*8]
    |-> REG_ENABLE_OUT) else $error("regulator off with select pin tied");
  chk_ready_now: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("access phase without ready");
  chk_vsel_update: assert property (wr_ok && PADDR_IN == `A_REG_VSEL
    |-> ##2 REG_VSEL_OUT == $past(PWDATA_IN[5:4], 2)) else $error("regulator select stale");
  chk_por_disable: assert property (wr_ok && PADDR_IN == `A_POR_CTRL
    |-> ##2 POR_ENABLE_OUT == !$past(PWDATA_IN[3], 2)) else $error("power-on reset enable stale");
  chk_spk_gain: assert property (wr_ok && PADDR_IN == `A_SPK_GAIN
    |-> ##2 DRIVE_OUT.spk_gain == $past(PWDATA_IN[6:4], 2)) else $error("speaker gain stale");

  cover property (wr_ok && PADDR_IN == `A_SPK_ENABLE);
  cover property (SPK_OVERCURRENT_IN [*8]);
  cover property (OVER_TEMP_IN [*8]);
endmodule : outstage_ctrl_asserts

bind outstage_ctrl outstage_ctrl_asserts outstage_ctrl_asserts_inst (
  .REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN), .POR_B_IN(POR_B_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .SPK_OVERCURRENT_IN(SPK_OVERCURRENT_IN),
  .OVER_TEMP_IN(OVER_TEMP_IN), .REGULATOR_SELECT_PIN_IN(REGULATOR_SELECT_PIN_IN),
  .DRIVE_OUT(DRIVE_OUT), .REG_ENABLE_OUT(REG_ENABLE_OUT), .REG_VSEL_OUT(REG_VSEL_OUT),
  .ANALOG_SUPPLY_OE_OUT(ANALOG_SUPPLY_OE_OUT), .CORE_SUPPLY_OE_OUT(CORE_SUPPLY_OE_OUT),
  .POR_ENABLE_OUT(POR_ENABLE_OUT)
);
`default_nettype wire

/* File: testbench/outstage_loads.sv */
// behavioural model of the headphone and speaker loads and the die temperature
`timescale 1ns/1ns
`default_nettype none
module outstage_loads import outstage_pkg::*; (
  // clock and driver controls
  input wire logic clk_in,
  input wire drive_t drive_in,
  // faults commanded by the bench
  input wire logic hp_fault_in,
  input wire logic spk_fault_in,
  input wire logic hot_in,
  // sense lines back to the block
  output logic hp_short_out,
  output logic spk_oc_out,
  output logic over_temp_out
);
  // ----------------------------------------
  // sense
  // ----------------------------------------
  // a shorted pin reads shorted even with the driver off, so a re-arm
  // against a standing fault is caught at once
  always_ff @(posedge clk_in) begin
    hp_short_out <= hp_fault_in;
    spk_oc_out <= spk_fault_in;
    // die stays hot while the stage keeps switching; cools once it stops
    over_temp_out <= hot_in || (over_temp_out && drive_in.spk_switch);
  end
endmodule : outstage_loads
`default_nettype wire

/* File: testbench/outstage_ctrl_bench.sv */
// self-checking bench for the output-stage control block
`timescale 1ns/1ns
`default_nettype none
`include "outstage_map.svh"
module outstage_ctrl_bench import outstage_pkg::*;;
  logic clk, rst_b, por_b, psel, penable, pwrite, pin_sel, hp_f, spk_f, hot, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdq;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, hp_s, spk_s, ot, reg_en, aoe, coe, por_en;
  wire logic [1:0] vsel;
  wire drive_t drive;
  int error_cnt = 0;
  int tests_run = 0;
  localparam logic [11:0] ADDR [11] = '{`A_SOFTSTEP, `A_POR_CTRL, `A_REG_VSEL, `A_HP_ENABLE,
    `A_HP_DRIVE, `A_HP_SHORT, `A_ROUTE, `A_HP_GAIN, `A_SPK_ENABLE, `A_SPK_VOL, `A_SPK_GAIN};
  localparam logic [31:0] RST_V [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h40, 32'h0, 32'h7F, 32'h10};
  localparam logic [31:0] MSK [11] = '{32'h3, 32'h8, 32'h30, 32'h20, 32'h4, 32'h2, 32'h8,
    32'h7F, 32'h2, 32'h7F, 32'h70};

  outstage_ctrl outstage_ctrl_inst (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1), .POR_B_IN(por_b),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .HP_SHORT_IN(hp_s), .SPK_OVERCURRENT_IN(spk_s), .OVER_TEMP_IN(ot),
    .REGULATOR_SELECT_PIN_IN(pin_sel), .DRIVE_OUT(drive), .REG_ENABLE_OUT(reg_en),
    .REG_VSEL_OUT(vsel), .ANALOG_SUPPLY_OE_OUT(aoe), .CORE_SUPPLY_OE_OUT(coe),
    .POR_ENABLE_OUT(por_en)
  );
  outstage_loads outstage_loads_inst (
    .clk_in(clk), .drive_in(drive), .hp_fault_in(hp_f), .spk_fault_in(spk_f), .hot_in(hot),
    .hp_short_out(hp_s), .spk_oc_out(spk_s), .over_temp_out(ot)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h, want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // bus access
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end else begin
      rdq = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, pin_sel, hp_f, spk_f, hot} = 8'h00;
    por_b = 1'b1;
    {paddr, pwdata} = 44'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, ADDR[i], 32'h0);
      check(rdq, RST_V[i]);
    end
    check(32'(por_en), 32'h1);
    $display("test defaults done");
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, ADDR[i], 32'hFFFFFFFF);
      apb(1'b0, ADDR[i], 32'h0);
      check(rdq, MSK[i]);
    end
    repeat (200) @(posedge clk);
    check(32'({drive.hp_on, drive.hp_half, drive.hp_mute, drive.hp_gain, drive.spk_on,
      drive.spk_switch, drive.spk_gain, drive.spk_atten, drive.spk_route}),
      32'({3'h7, 6'h3F, 2'h3, 3'h7, 7'h75, 1'b1}));
    check(32'({vsel, por_en}), 32'h6);
    apb(1'b0, 12'h0F0, 32'h0);
    check(32'({rdq, slv}), 32'h1);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, `A_REG_VSEL, 32'(v) << 4);
      repeat (3) @(posedge clk);
      check(32'(vsel), 32'(v));
    end
    pin_sel <= 1'b1;
    repeat (8) @(posedge clk);
    check(32'({reg_en, aoe, coe}), 32'h7);
    pin_sel <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'({reg_en, aoe, coe}), 32'h0);
    $display("test registers and regulator done");
    apb(1'b1, `A_HP_SHORT, 32'h0);
    hp_f <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'({drive.hp_on, drive.hp_limit}), 32'h3);
    apb(1'b0, `A_HP_ENABLE, 32'h0);
    check(rdq, 32'h20);
    apb(1'b0, `A_HP_FLAGS, 32'h0);
    check(rdq, 32'h80);
    apb(1'b1, `A_HP_SHORT, 32'h2);
    repeat (8) @(posedge clk);
    apb(1'b0, `A_HP_ENABLE, 32'h0);
    check(32'({rdq[5], drive.hp_on}), 32'h0);
    apb(1'b1, `A_HP_ENABLE, 32'h20);
    repeat (8) @(posedge clk);
    apb(1'b0, `A_HP_ENABLE, 32'h0);
    check(rdq, 32'h0);
    hp_f <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b1, `A_HP_ENABLE, 32'h20);
    apb(1'b0, `A_HP_ENABLE, 32'h0);
    check(rdq, 32'h20);
    apb(1'b0, `A_HP_GAIN, 32'h0);
    check(rdq, 32'h7F);
    spk_f <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, `A_SPK_ENABLE, 32'h0);
    check(32'({rdq[1], drive.spk_on}), 32'h0);
    spk_f <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b1, `A_SPK_ENABLE, 32'h2);
    apb(1'b0, `A_SPK_ENABLE, 32'h0);
    check(rdq, 32'h2);
    apb(1'b0, `A_SPK_GAIN, 32'h0);
    check(rdq, 32'h70);
    $display("test faults done");
    hot <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, `A_SPK_FLAGS, 32'h0);
    check(rdq, 32'h80);
    check(32'({drive.spk_on, drive.spk_switch}), 32'h2);
    hot <= 1'b0;
    repeat (10) @(posedge clk);
    check(32'(drive.spk_switch), 32'h1);
    apb(1'b1, `A_SOFTSTEP, 32'h0);
    apb(1'b1, `A_SPK_VOL, 32'h70);
    repeat (100) @(posedge clk);
    check(32'(drive.spk_atten), 32'h75);
    repeat (3500) @(posedge clk);
    check(32'(drive.spk_atten), 32'h70);
    apb(1'b1, `A_SOFTSTEP, 32'h3);
    apb(1'b1, `A_SPK_VOL, 32'h0);
    repeat (400) @(posedge clk);
    check(32'(drive.spk_atten), 32'h0);
    apb(1'b1, `A_SPK_VOL, 32'h7C);
    repeat (400) @(posedge clk);
    check(32'(drive.spk_atten), 32'h75);
    $display("test volume done");
    apb(1'b1, `A_SW_RESET, 32'h1);
    repeat (3) @(posedge clk);
    apb(1'b0, `A_HP_GAIN, 32'h0);
    check(rdq, 32'h40);
    check(32'(por_en), 32'h1);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `A_POR_CTRL, k ? 32'h8 : 32'h0);
      apb(1'b1, `A_SPK_GAIN, 32'h30);
      por_b <= 1'b0;
      repeat (6) @(posedge clk);
      por_b <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, `A_SPK_GAIN, 32'h0);
      check(rdq, k ? 32'h30 : 32'h10);
    end
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, `A_SPK_GAIN, 32'h0);
    check(rdq, 32'h10);
    $display("test resets done");
    tally_and_finish();
  end
endmodule : outstage_ctrl_bench
`default_nettype wire
